// >>> src/sep_command_port.sv
// spi eeprom command port with its write-data fifo
`timescale 1ns/1ps
// Notes on behaviour
// - commands land in an eight-bit register shifted in from serial input
// - serial input sampled on every rising serial clock while selected and not held
// - every byte travels most significant bit first, both directions
// - first bit taken on first rising clock after chip select falls
// - hold freezes the transfer; release resumes exactly where it stopped
// - 03h reads the array, 02h writes the array, from given address
// - 06h sets the write latch, 04h clears it
// - 42h page erase, D8h sector erase, C7h chip erase recognised
// - ABh wakes and returns signature, B9h enters deep sleep
// - read takes 24-bit address, top seven ignored, then shifts data out
// - read address advances per byte and wraps 1FFFFh to 00000h
// - chip select high ends a read
// - write latch set only when select rises after the full instruction
// - each write erases its target itself, no separate erase needed
// - write frame is instruction, 24-bit address, 1 to 256 bytes
// - data past page end wraps to page start and overwrites
// - unaddressed bytes of the page keep their contents
// - write starts only if select rises right after a whole byte
// - status reads still work during a write, array reads do not
// - write latch clears when the internal write cycle ends
// - status bit 0 is busy, bit 1 is write latch, read-only
// - internal write cycle finishes within 6 ms

module sep_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // count is one bit wider than the pointers when DEPTH is a power of two, so full and empty differ
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [CNT_W-1:0] count;
    } sep_fifo_state_type;

    sep_fifo_state_type q;
    sep_fifo_state_type d;
    logic [WIDTH-1:0] store [DEPTH];
    logic doPush;
    logic doPop;

    assign inReady = (q.count != CNT_FULL);
    assign outValid = (q.count != '0);
    assign outData = store[q.rdPtr];

    always_comb begin
        d = q;
        doPush = inValid && inReady;
        doPop = outValid && outReady;
        if (doPush) begin
            d.wrPtr = (q.wrPtr == PTR_LAST) ? '0 : q.wrPtr + 1'b1;
        end
        if (doPop) begin
            d.rdPtr = (q.rdPtr == PTR_LAST) ? '0 : q.rdPtr + 1'b1;
        end
        if (doPush && !doPop) begin
            d.count = q.count + 1'b1;
        end else if (doPop && !doPush) begin
            d.count = q.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            store[q.wrPtr] <= inData;
        end
    end
endmodule : sep_fifo

module sep_command_port #(
    parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES,
    parameter logic [7:0] SIGNATURE = sep_pkg::SIGNATURE_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    output logic soData,
    output logic soOe
);
    localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] TIMER_COPY = TIMER_W'(sep_pkg::PAGE_BYTES);
    localparam logic [8:0] COUNT_MAX = 9'h1FF;

    typedef struct packed {
        sep_pkg::sep_pins_type pinM;
        sep_pkg::sep_pins_type pinS;
        logic sckPrev;
        logic csPrev;
        sep_pkg::sep_phase_type phase;
        logic [7:0] shiftIn;
        logic [2:0] bitCnt;
        logic [1:0] addrByte;
        logic [7:0] cmd;
        logic [sep_pkg::ADDR_W-1:0] addr;
        logic [7:0] outShift;
        logic [2:0] outCnt;
        logic outActive;
        logic soData;
        logic soOe;
        logic write_latch_flag;
        logic busy;
        logic sleep;
        logic [8:0] wrCount;
        logic wrPending;
        logic frameBad;
        logic maskClr;
        logic [TIMER_W-1:0] timer;
        logic [sep_pkg::ADDR_W-sep_pkg::PAGE_W-1:0] pageBase;
    } sep_state_type;

    localparam sep_state_type STATE_RESET = '{
        pinM: sep_pkg::PINS_IDLE,
        pinS: sep_pkg::PINS_IDLE,
        csPrev: 1'b1,
        phase: sep_pkg::PH_CMD,
        default: '0
    };

    sep_state_type q;
    sep_state_type d;

    logic [7:0] memArr [sep_pkg::MEM_BYTES];
    logic [7:0] pageBuf [sep_pkg::PAGE_BYTES];
    logic [sep_pkg::PAGE_BYTES-1:0] pageMask;

    logic selected;
    logic held;
    logic rise;
    logic fall;
    logic csRise;
    logic [7:0] byteNow;
    logic [7:0] loadByte;
    logic [7:0] statusByte;
    logic [sep_pkg::ADDR_W-1:0] nextAddr;
    logic copyEn;
    logic [7:0] copyIdx;
    logic fifoInValid;
    sep_pkg::sep_item_type fifoInItem;
    logic fifoInReady;
    logic fifoOutValid;
    sep_pkg::sep_item_type fifoOutItem;
    logic fifoOutReady;

    assign soData = q.soData;
    assign soOe = q.soOe;

    sep_fifo #(
        .WIDTH($bits(sep_pkg::sep_item_type)),
        .DEPTH(sep_pkg::FIFO_DEPTH)
    ) writeFifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(fifoInValid),
        .inData(fifoInItem),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutItem),
        .outReady(fifoOutReady)
    );

    always_comb begin
        d = q;
        d.maskClr = 1'b0;
        fifoInValid = 1'b0;
        fifoInItem = '0;
        copyEn = 1'b0;
        copyIdx = q.timer[7:0];
        // page buffer is frozen while its contents are being committed
        fifoOutReady = !q.busy;
        // first stage feeds only the second
        d.pinM = '{csN: csN, sck: sck, si: si, holdN: holdN};
        d.pinS = q.pinM;
        d.sckPrev = q.pinS.sck;
        d.csPrev = q.pinS.csN;
        selected = !q.pinS.csN;
        held = !q.pinS.holdN;
        rise = q.pinS.sck && !q.sckPrev;
        fall = !q.pinS.sck && q.sckPrev;
        csRise = q.pinS.csN && !q.csPrev;
        byteNow = {q.shiftIn[6:0], q.pinS.si};
        nextAddr = {q.addr[8:0], byteNow};
        statusByte = '0;
        statusByte[sep_pkg::STATUS_BUSY_BIT] = q.busy;
        statusByte[sep_pkg::STATUS_LATCH_BIT] = q.write_latch_flag;
        if (q.cmd == sep_pkg::READ_CMD) begin
            loadByte = memArr[q.addr];
        end else if (q.cmd == sep_pkg::STATUS_READ_CMD) begin
            loadByte = statusByte;
        end else begin
            loadByte = SIGNATURE;
        end

        if (!selected) begin
            d.phase = sep_pkg::PH_CMD;
            d.bitCnt = '0;
            d.addrByte = '0;
            d.outActive = 1'b0;
            d.outCnt = '0;
            d.frameBad = 1'b0;
            if (csRise && q.bitCnt == '0 && !q.frameBad && !q.busy && !q.sleep) begin
                if (q.cmd == sep_pkg::SET_WRITE_LATCH_CMD && q.phase == sep_pkg::PH_DONE) begin
                    d.write_latch_flag = 1'b1;
                end
                if (q.cmd == sep_pkg::WRITE_CMD && q.phase == sep_pkg::PH_DATA
                        && q.wrCount != '0) begin
                    d.wrPending = 1'b1;
                end
                if (q.cmd == sep_pkg::DEEP_SLEEP_CMD && q.phase == sep_pkg::PH_DONE) begin
                    d.sleep = 1'b1;
                end
            end
        end else if (!held) begin
            // while held nothing below moves, so release resumes in place
            if (rise) begin
                d.shiftIn = byteNow;
                d.bitCnt = q.bitCnt + 1'b1;
                if (q.phase == sep_pkg::PH_DONE) begin
                    d.frameBad = 1'b1;
                end
                if (q.bitCnt == sep_pkg::LAST_BIT) begin
                    case (q.phase)
                        sep_pkg::PH_CMD: begin
                            d.cmd = byteNow;
                            d.phase = sep_pkg::PH_DONE;
                            if (q.sleep) begin
                                if (byteNow == sep_pkg::WAKE_AND_SIGNATURE_CMD) begin
                                    d.sleep = 1'b0;
                                    d.phase = sep_pkg::PH_DATA;
                                end
                            end else if (byteNow == sep_pkg::READ_CMD) begin
                                d.phase = q.busy ? sep_pkg::PH_DONE : sep_pkg::PH_ADDR;
                            end else if (byteNow == sep_pkg::WRITE_CMD) begin
                                if (!q.busy && q.write_latch_flag) begin
                                    d.phase = sep_pkg::PH_ADDR;
                                end
                            end else if (byteNow == sep_pkg::CLEAR_WRITE_LATCH_CMD) begin
                                if (!q.busy) begin
                                    d.write_latch_flag = 1'b0;
                                end
                            end else if (byteNow == sep_pkg::STATUS_READ_CMD
                                    || byteNow == sep_pkg::WAKE_AND_SIGNATURE_CMD) begin
                                d.phase = sep_pkg::PH_DATA;
                            end else if (byteNow == sep_pkg::PAGE_ERASE_CMD
                                    || byteNow == sep_pkg::SECTOR_ERASE_CMD
                                    || byteNow == sep_pkg::CHIP_ERASE_CMD) begin
                                // erase recognised only; the array is left as it is
                                d.phase = sep_pkg::PH_DONE;
                            end else if (byteNow == sep_pkg::STATUS_WRITE_CMD) begin
                                // protection bits are out of scope, frame is swallowed
                                d.phase = sep_pkg::PH_DONE;
                            end
                            // latch set and sleep wait in done for the frame end
                        end
                        sep_pkg::PH_ADDR: begin
                            d.addr = nextAddr;
                            d.addrByte = q.addrByte + 1'b1;
                            if (q.addrByte == sep_pkg::LAST_ADDR_BYTE) begin
                                d.phase = sep_pkg::PH_DATA;
                                d.wrCount = '0;
                                d.pageBase = nextAddr[sep_pkg::ADDR_W-1:sep_pkg::PAGE_W];
                                d.maskClr = (q.cmd == sep_pkg::WRITE_CMD);
                            end
                        end
                        sep_pkg::PH_DATA: begin
                            if (q.cmd == sep_pkg::WRITE_CMD) begin
                                fifoInValid = 1'b1;
                                fifoInItem = '{offset: q.addr[7:0], data: byteNow};
                                d.addr[7:0] = q.addr[7:0] + 8'h01;
                                if (q.wrCount != COUNT_MAX) begin
                                    d.wrCount = q.wrCount + 9'h001;
                                end
                                // a lost byte must never commit a torn page
                                if (!fifoInReady) begin
                                    d.frameBad = 1'b1;
                                end
                            end
                        end
                        default: begin
                            d.phase = sep_pkg::PH_DONE;
                        end
                    endcase
                end
            end
            if (fall && q.phase == sep_pkg::PH_DATA && q.cmd != sep_pkg::WRITE_CMD) begin
                d.outActive = 1'b1;
                d.outCnt = q.outCnt + 1'b1;
                if (q.outCnt == '0) begin
                    d.soData = loadByte[7];
                    d.outShift = {loadByte[6:0], 1'b0};
                    if (q.cmd == sep_pkg::READ_CMD) begin
                        d.addr = q.addr + 1'b1;
                    end
                end else begin
                    d.soData = q.outShift[7];
                    d.outShift = {q.outShift[6:0], 1'b0};
                end
            end
        end
        d.soOe = selected && !held && d.outActive;

        if (q.wrPending && !fifoOutValid) begin
            d.wrPending = 1'b0;
            d.busy = 1'b1;
            d.timer = '0;
        end
        if (q.busy) begin
            d.timer = q.timer + 1'b1;
            copyEn = (q.timer < TIMER_COPY);
            if (q.timer == TIMER_LAST) begin
                d.busy = 1'b0;
                d.write_latch_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // array and page buffer carry no reset; only the byte mask does
    always_ff @(posedge core_clk) begin
        if (rst || q.maskClr) begin
            pageMask <= '0;
        end else if (fifoOutValid && fifoOutReady) begin
            pageBuf[fifoOutItem.offset] <= fifoOutItem.data;
            pageMask[fifoOutItem.offset] <= 1'b1;
        end
        if (copyEn && pageMask[copyIdx]) begin
            memArr[{q.pageBase, copyIdx}] <= pageBuf[copyIdx];
        end
    end
endmodule : sep_command_port

// >>> pkg/sep_pkg.sv
// constants and carrier types for the serial eeprom command port
package sep_pkg;
    localparam int ADDR_W = 17;
    localparam int PAGE_W = 8;
    localparam int PAGE_BYTES = 256;
    localparam int MEM_BYTES = 131072;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_HZ = 10000000;
    localparam int WRITE_TIME_MS = 6;
    // longest time, so round down
    localparam int WRITE_CYCLES = (WRITE_TIME_MS * CLK_HZ) / 1000;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LATCH_BIT = 1;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] WRITE_CMD = 8'h02;
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_ERASE_CMD = 8'h42;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD = 8'hC7;
    localparam logic [7:0] WAKE_AND_SIGNATURE_CMD = 8'hAB;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
    // arbitrary signature value
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11,
        PH_DONE = 2'b10
    } sep_phase_type;

    typedef struct packed {
        logic csN;
        logic sck;
        logic si;
        logic holdN;
    } sep_pins_type;

    localparam sep_pins_type PINS_IDLE = '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1};

    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] data;
    } sep_item_type;
endpackage : sep_pkg

// >>> testbench/sep_command_port_properties.sv
// pin-level checks beside the serial eeprom port
`timescale 1ns/1ps
module sep_command_port_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic soData,
    input wire logic soOe
);
    logic [7:0] riseCnt;
    logic sckPrev;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // counts raw pin rises, so it leads the synchronised view
    always_ff @(posedge core_clk) begin
        sckPrev <= sck;
        if (rst || csN) begin
            riseCnt <= 8'h00;
        end else if (sck && !sckPrev && holdN && riseCnt != 8'hFF) begin
            riseCnt <= riseCnt + 8'h01;
        end
    end
    sequence deselected_s; csN [*5]; endsequence
    sequence held_s; (!csN && !holdN) [*5]; endsequence
    sequence shifting_high_s; (soOe && sck) [*5]; endsequence
    AST_RESET_QUIET: assert property ($past(rst) |-> !soOe) else $error("so after reset");
    AST_CS_RISE_OFF: assert property ($rose(csN) |-> ##[1:4] !soOe) else $error("so on");
    AST_DESELECT_QUIET: assert property (deselected_s |-> !soOe) else $error("so idle");
    AST_HOLD_QUIET: assert property (held_s |-> !soOe) else $error("so in hold");
    AST_OE_NEEDS_SELECT: assert property ($rose(soOe) |-> !csN && $past(holdN, 2))
        else $error("so unselected");
    AST_OE_AFTER_BYTE: assert property ($rose(soOe) |-> riseCnt >= 8'h08)
        else $error("so early");
    AST_SHIFT_ON_FALL: assert property (soOe && $past(soOe) && $changed(soData) |-> !sck)
        else $error("so shift high");
    AST_STABLE_HIGH: assert property (shifting_high_s |-> $stable(soData))
        else $error("so moved");
endmodule : sep_command_port_properties

// >>> testbench/sep_host_model.sv
// host spi controller model, mode 0, sampling so on sck rise
`timescale 1ns/1ps
module sep_host_model #(
    parameter int HALF = 6
) (
    input wire logic core_clk,
    output logic csN,
    output logic sck,
    output logic si,
    output logic holdN,
    input wire logic soData,
    input wire logic soOe
);
    int holdAt = -1;
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
    end
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_cycles
    task automatic select();
        @(posedge core_clk);
        csN <= 1'b0;
    endtask : select
    task automatic deselect();
        @(posedge core_clk);
        sck <= 1'b0;
        wait_cycles(HALF);
        csN <= 1'b1;
        si <= ~si; // released line must not look steady
        wait_cycles(8);
    endtask : deselect
    // n below 8 leaves the byte partial on purpose
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge core_clk);
            sck <= 1'b0;
            if (i == holdAt) begin
                // let the fall reach the device before pausing it
                wait_cycles(4);
                holdN <= 1'b0;
                wait_cycles(10);
                holdN <= 1'b1;
                wait_cycles(HALF);
            end
            si <= tx[i];
            wait_cycles(HALF);
            sck <= 1'b1;
            #1;
            rx[i] = soOe ? soData : 1'bz;
            wait_cycles(HALF - 1);
        end
    endtask : xfer
endmodule : sep_host_model

// >>> testbench/sep_command_port_test.sv
// self-checking bench for the serial eeprom command port
`timescale 1ns/1ps
module sep_command_port_test;
    localparam int WCYC = 2000;
    localparam logic [7:0] SIG = 8'h3C; // arbitrary signature value
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic csN, sck, si, holdN, soData, soOe;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] rx;
    logic [7:0] q[$];
    always #50 core_clk = ~core_clk;
    sep_command_port #(.WRITE_CYCLES(WCYC), .SIGNATURE(SIG)) dut (.core_clk(core_clk),
        .rst(rst), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .soData(soData), .soOe(soOe));
    sep_host_model host (.core_clk(core_clk), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
        .soData(soData), .soOe(soOe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic cmd1(input logic [7:0] c);
        host.select();
        host.xfer(c, 8, rx);
        host.deselect();
    endtask : cmd1
    task automatic get_status(output logic [7:0] s);
        host.select();
        host.xfer(sep_pkg::STATUS_READ_CMD, 8, s);
        host.xfer(8'h00, 8, s);
        host.deselect();
    endtask : get_status
    task automatic read_bytes(input logic [23:0] a, input int n);
        q = {};
        host.select();
        host.xfer(sep_pkg::READ_CMD, 8, rx);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], 8, rx);
        repeat (n) begin
            host.xfer(8'h00, 8, rx);
            q.push_back(rx);
        end
        host.deselect();
    endtask : read_bytes
    // latch frame first, then data; tail bits leave a partial byte
    task automatic write_bytes(input logic [23:0] a, input logic [7:0] d[$], input int tail);
        cmd1(sep_pkg::SET_WRITE_LATCH_CMD);
        host.select();
        host.xfer(sep_pkg::WRITE_CMD, 8, rx);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], 8, rx);
        foreach (d[i]) host.xfer(d[i], 8, rx);
        if (tail > 0) host.xfer(8'hFF, tail, rx);
        host.deselect();
    endtask : write_bytes
    // bounded poll; caller judges the final status
    task automatic wait_idle();
        repeat (30) begin
            get_status(rx);
            if (rx[0] === 1'b0) break;
        end
    endtask : wait_idle
    task automatic t_latch();
        get_status(rx);
        check(rx, 8'h00);
        cmd1(sep_pkg::SET_WRITE_LATCH_CMD);
        get_status(rx);
        check(rx, 8'h02);
        cmd1(sep_pkg::CLEAR_WRITE_LATCH_CMD);
        get_status(rx);
        check(rx, 8'h00);
        host.select();
        host.xfer(sep_pkg::SET_WRITE_LATCH_CMD, 8, rx);
        host.xfer(8'h00, 3, rx);
        host.deselect();
        get_status(rx);
        check(rx, 8'h00);
        host.select();
        host.xfer(sep_pkg::STATUS_READ_CMD, 4, rx);
        host.deselect();
        get_status(rx);
        check(rx, 8'h00);
        host.select();
        host.xfer(sep_pkg::SECTOR_ERASE_CMD, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.deselect();
        check(rx, 8'hZZ);
    endtask : t_latch
    task automatic t_page();
        write_bytes(24'h000100, '{8'h11, 8'h22}, 0);
        wait_idle();
        check(rx, 8'h00);
        write_bytes(24'hFE01FE, '{8'hA1, 8'hB2, 8'hC3}, 0);
        get_status(rx);
        check(rx, 8'h03);
        read_bytes(24'h000100, 1);
        check(q[0], 8'hZZ);
        wait_idle();
        check(rx, 8'h00);
        read_bytes(24'h000100, 2);
        check(q[0], 8'hC3);
        check(q[1], 8'h22);
        read_bytes(24'h0001FE, 2);
        check(q[0], 8'hA1);
        check(q[1], 8'hB2);
    endtask : t_page
    task automatic t_wrap();
        write_bytes(24'h01FFFF, '{8'h77}, 0);
        wait_idle();
        write_bytes(24'h000000, '{8'h66}, 0);
        wait_idle();
        read_bytes(24'hFFFFFF, 2);
        check(q[0], 8'h77);
        check(q[1], 8'h66);
    endtask : t_wrap
    task automatic t_abort();
        write_bytes(24'h000000, '{8'h55}, 3);
        get_status(rx);
        check(rx, 8'h02);
        read_bytes(24'h000000, 1);
        check(q[0], 8'h66);
        cmd1(sep_pkg::CLEAR_WRITE_LATCH_CMD);
    endtask : t_abort
    task automatic t_hold_sleep();
        host.holdAt = 3;
        read_bytes(24'h000100, 1);
        host.holdAt = -1;
        check(q[0], 8'hC3);
        cmd1(sep_pkg::DEEP_SLEEP_CMD);
        get_status(rx);
        check(rx, 8'hZZ);
        host.select();
        host.xfer(sep_pkg::WAKE_AND_SIGNATURE_CMD, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.deselect();
        check(rx, SIG);
        get_status(rx);
        check(rx, 8'h00);
    endtask : t_hold_sleep
    initial begin
        repeat (80000) @(posedge core_clk);
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_latch();
        t_page();
        t_wrap();
        t_abort();
        t_hold_sleep();
        finish_test();
    end
endmodule : sep_command_port_test
bind sep_command_port sep_command_port_properties chk (.core_clk(core_clk), .rst(rst),
    .csN(csN), .sck(sck), .si(si), .holdN(holdN), .soData(soData), .soOe(soOe));
